// *** motor_pkg.sv ***
package motor_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000; // reference clock rate
    localparam int CLK_PERIOD_NS = 25; // reference clock period
    localparam int BLANK_NS = 1000; // least blanking after cycle start
    localparam int MARGIN_NS = 500; // least diode time before auto-on
    localparam int DEAD_NS = 100; // least both-off time per leg
    localparam int SLOW_PWM_HZ = 20_000; // internal restart, slow
    localparam int FAST_PWM_HZ = 40_000; // internal restart, fast
    localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MARGIN_CYC = (MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEAD_CYC = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] BLANK_LOAD = 6'(BLANK_CYC); // blank counter load
    localparam logic [5:0] MARGIN_DONE = 6'(MARGIN_CYC); // margin count end
    localparam logic [2:0] DEAD_DONE = 3'(DEAD_CYC); // dead count end
    localparam logic [10:0] SLOW_LAST = 11'(CLK_HZ / SLOW_PWM_HZ - 1);
    localparam logic [10:0] FAST_LAST = 11'(CLK_HZ / FAST_PWM_HZ - 1);
    // ----------------------------------------------------------------
    // four-level strap codes and bit meaning
    // ----------------------------------------------------------------
    localparam logic [1:0] STRAP_GND = 2'h0; // off, 16 A
    localparam logic [1:0] STRAP_GND_RES = 2'h1; // off, 24 A
    localparam logic [1:0] STRAP_OPEN = 2'h2; // on, 16 A
    localparam logic [1:0] STRAP_AVDD = 2'h3; // on, 24 A
    localparam int STRAP_OCP_BIT = 0; // set: 24 A level
    localparam int STRAP_SR_BIT = 1; // set: rectification on
    // ----------------------------------------------------------------
    // register map, 8-bit data
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_CFG = 4'h0; // configuration
    localparam logic [3:0] ADDR_STATUS = 4'h1; // live state
    localparam logic [3:0] ADDR_GATES = 4'h2; // gate outputs
    localparam logic [7:0] CFG_RESET = 8'h00; // all features off
    localparam int CFG_SYNC = 0; // sync_rectify_enable
    localparam int CFG_ASYNC = 1; // async_rectify_enable
    localparam int CFG_BRAKE = 2; // limit_recirculation_select
    localparam int CFG_FAST = 3; // internal clock 40 kHz
    localparam int CFG_OCP = 4; // overcurrent level 24 A
    localparam int CFG_GAIN = 5; // gain field low bit, two bits
    localparam int ST_LIMIT = 0; // limit flag
    localparam int ST_BLANK = 1; // blanking active
    localparam int ST_DEMAG = 2; // demag enabled
    localparam int ST_OCP = 3; // overcurrent level
    localparam int ST_AUTO = 4; // auto-on per leg, three bits
    localparam int GT_LS = 3; // low-side gates field in gates word
endpackage

// *** int_pwm_tick.sv ***
// ----------------------------------------------------------------
// internal restart clock for full-duty inputs
// ----------------------------------------------------------------
module int_pwm_tick (
    input wire logic ref_clk_i, // reference clock
    input wire logic rst_n_i, // synchronous reset, low
    input wire logic ce_i, // clock enable
    input wire logic fast_i, // high: 40 kHz, low: 20 kHz
    output logic tick_o // one-cycle restart pulse
);
    logic [10:0] cnt_ff; // free-running period count
    logic [10:0] last_w; // final count of this period
    logic wrap_w; // period ends now

    // a shortened period after a select change wraps at once
    assign last_w = fast_i ? motor_pkg::FAST_LAST : motor_pkg::SLOW_LAST;
    assign wrap_w = (cnt_ff >= last_w);

    // counter and pulse
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cnt_ff <= 11'h000;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            cnt_ff <= wrap_w ? 11'h000 : cnt_ff + 11'h001;
            tick_o <= wrap_w;
        end
    end
endmodule

// *** leg_ctrl.sv ***
// ----------------------------------------------------------------
// one half-bridge: demagnetization and dead time
// ----------------------------------------------------------------
module leg_ctrl (
    input wire logic ref_clk_i, // reference clock
    input wire logic rst_n_i, // synchronous reset, low
    input wire logic ce_i, // clock enable
    input wire logic demag_en_i, // rectification enabled
    input wire logic hs_cmd_i, // high side wanted
    input wire logic ls_cmd_i, // low side wanted
    input wire logic hs_hold_i, // limit holds high side off
    input wire logic hs_rev_i, // high_side_reverse_comparator
    input wire logic ls_rev_i, // low_side_reverse_comparator
    output logic hs_gate_o, // high-side gate
    output logic ls_gate_o, // low-side gate
    output logic auto_o // automatic turn-on active
);
    typedef enum logic [2:0] {
        LEG_DEAD = 3'h1, // both off
        LEG_HS = 3'h2, // high side on
        LEG_LS = 3'h4 // low side on
    } leg_state_e;

    leg_state_e state_ff, nxt_state; // leg state
    logic [2:0] dead_ff; // both-off time so far
    logic [5:0] ls_margin_ff, hs_margin_ff; // diode time so far
    logic armed_ff, cut_ff; // decay seen, low side cut

    function automatic logic [5:0] sat_up(input logic [5:0] v);
        sat_up = (v == motor_pkg::MARGIN_DONE) ? v : v + 6'h01;
    endfunction

    // diode conduction while neither FET is commanded
    wire ls_diode_w = demag_en_i & ~hs_cmd_i & ~ls_cmd_i & ls_rev_i;
    wire hs_diode_w = demag_en_i & ~hs_cmd_i & ~ls_cmd_i & ~hs_hold_i & hs_rev_i;
    // on only after the margin; drops as soon as the comparator clears
    wire ls_auto_w = ls_diode_w & (ls_margin_ff == motor_pkg::MARGIN_DONE);
    wire hs_auto_w = hs_diode_w & (hs_margin_ff == motor_pkg::MARGIN_DONE);
    wire ls_eff_w = ls_cmd_i & ~cut_ff;
    wire want_hs_w = (hs_cmd_i | hs_auto_w) & ~(ls_eff_w | ls_auto_w);
    wire want_ls_w = (ls_eff_w | ls_auto_w) & ~(hs_cmd_i | hs_auto_w);
    wire dead_ok_w = (dead_ff == motor_pkg::DEAD_DONE);

    // next state: every change passes through the dead state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            LEG_HS: if (!want_hs_w) nxt_state = LEG_DEAD;
            LEG_LS: if (!want_ls_w) nxt_state = LEG_DEAD;
            LEG_DEAD: begin
                if (dead_ok_w && want_hs_w) nxt_state = LEG_HS;
                else if (dead_ok_w && want_ls_w) nxt_state = LEG_LS;
            end
            default: nxt_state = LEG_DEAD;
        endcase
    end

    // state, gates, counters
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_ff <= LEG_DEAD;
            hs_gate_o <= 1'b0;
            ls_gate_o <= 1'b0;
            auto_o <= 1'b0;
            dead_ff <= 3'h0;
            ls_margin_ff <= 6'h00;
            hs_margin_ff <= 6'h00;
            armed_ff <= 1'b0;
            cut_ff <= 1'b0;
        end else if (ce_i) begin
            state_ff <= nxt_state;
            hs_gate_o <= (nxt_state == LEG_HS);
            ls_gate_o <= (nxt_state == LEG_LS);
            auto_o <= ls_auto_w | hs_auto_w;
            dead_ff <= (state_ff != LEG_DEAD) ? 3'h0 : (dead_ok_w ? dead_ff : dead_ff + 3'h1);
            ls_margin_ff <= ls_diode_w ? sat_up(ls_margin_ff) : 6'h00;
            hs_margin_ff <= hs_diode_w ? sat_up(hs_margin_ff) : 6'h00;
            // decay current seen, then its loss means near zero
            armed_ff <= ls_cmd_i & (armed_ff | ls_rev_i);
            cut_ff <= ls_cmd_i & demag_en_i & (cut_ff | (armed_ff & ~ls_rev_i));
        end
    end

    // once cut, the low side must be off by the next edge
    property p_cut_low;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && cut_ff |=> !ls_gate_o;
    endproperty
    a_cut_low: assert property (p_cut_low) else $error("low side kept past zero");
endmodule

// *** motor_bridge_demag_current_limit.sv ***
// ----------------------------------------------------------------
// three-leg bridge control: demag, current limit, registers
// ----------------------------------------------------------------
module motor_bridge_demag_current_limit (
    input wire logic ref_clk_i, // 40 MHz reference clock
    input wire logic rst_n_i, // synchronous reset, low
    input wire logic ce_i, // clock enable, low freezes
    input wire logic [2:0] high_side_phase_input_i, // high-side commands
    input wire logic [2:0] low_side_phase_input_i, // low-side commands
    input wire logic driver_disable_input_i, // high: all gates off
    input wire logic [2:0] high_side_reverse_comparator_i, // out to supply
    input wire logic [2:0] low_side_reverse_comparator_i, // ground to out
    input wire logic limit_cmp_i, // sense sum beyond limit threshold
    input wire logic pin_config_i, // high: pin-configured variant
    input wire logic [1:0] protect_rectify_strap_i, // four-level strap
    input wire logic [1:0] gain_strap_i, // four-level gain strap
    input wire logic [3:0] addr_i, // register address
    input wire logic [7:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [7:0] rdata_o, // read data, cycle after strobe
    output logic [2:0] hs_gate_o, // high-side gates
    output logic [2:0] ls_gate_o, // low-side gates
    output logic [1:0] sense_gain_o, // current-sense gain level
    output logic ocp_24a_o // overcurrent level: high 24 A
);
    // ----------------------------------------------------------------
    // configuration
    // ----------------------------------------------------------------
    logic [7:0] cfg_ff; // software configuration
    logic [1:0] strap_ff; // latched rectify strap
    logic [1:0] gain_strap_ff; // latched gain strap
    logic strap_taken_ff; // straps captured since reset
    logic [7:0] rdata_w; // selected read word

    // straps are caught once, the first enabled edge after reset
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            strap_ff <= motor_pkg::STRAP_GND;
            gain_strap_ff <= 2'h0;
            strap_taken_ff <= 1'b0;
        end else if (ce_i && !strap_taken_ff) begin
            strap_ff <= protect_rectify_strap_i;
            gain_strap_ff <= gain_strap_i;
            strap_taken_ff <= 1'b1;
        end
    end

    // register variant takes both enables; pin variant the strap
    wire reg_demag_w = cfg_ff[motor_pkg::CFG_SYNC] & cfg_ff[motor_pkg::CFG_ASYNC];
    wire demag_en_w = pin_config_i ? strap_ff[motor_pkg::STRAP_SR_BIT] : reg_demag_w;
    wire ocp_w = pin_config_i ? strap_ff[motor_pkg::STRAP_OCP_BIT]
        : cfg_ff[motor_pkg::CFG_OCP];
    wire [1:0] gain_w = pin_config_i ? gain_strap_ff
        : cfg_ff[motor_pkg::CFG_GAIN +: 2];
    // no recirculation select in the pin variant: stays high impedance
    wire brake_w = ~pin_config_i & cfg_ff[motor_pkg::CFG_BRAKE];
    wire fast_w = ~pin_config_i & cfg_ff[motor_pkg::CFG_FAST];

    // ----------------------------------------------------------------
    // cycle start, blanking and limit flag
    // ----------------------------------------------------------------
    logic [2:0] hs_prev_ff; // last high-side commands
    logic [5:0] blank_cnt_ff; // blanking cycles left
    logic limit_flag_ff; // per-cycle current-limit trip
    logic tick_w; // internal restart pulse

    int_pwm_tick u_tick (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .fast_i(fast_w),
        .tick_o(tick_w)
    );

    wire hs_any_w = |high_side_phase_input_i; // some high side commanded
    wire hs_rise_w = |(high_side_phase_input_i & ~hs_prev_ff); // new PWM cycle
    // a held full-duty input restarts on the internal clock
    wire cycle_start_w = hs_rise_w | (tick_w & hs_any_w);
    wire blanking_w = cycle_start_w | (blank_cnt_ff != 6'h00);
    wire trip_w = limit_cmp_i & ~blanking_w;
    // trip outranks the restart, though blanking keeps them apart
    wire nxt_limit_flag = trip_w | (limit_flag_ff & ~cycle_start_w);
    wire brake_hold_w = limit_flag_ff & brake_w;

    // flag and blanking counter
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            hs_prev_ff <= 3'h0;
            blank_cnt_ff <= 6'h00;
            limit_flag_ff <= 1'b0;
        end else if (ce_i) begin
            hs_prev_ff <= high_side_phase_input_i;
            if (cycle_start_w) begin
                blank_cnt_ff <= motor_pkg::BLANK_LOAD;
            end else if (blank_cnt_ff != 6'h00) begin
                blank_cnt_ff <= blank_cnt_ff - 6'h01;
            end
            limit_flag_ff <= nxt_limit_flag;
        end
    end

    // ----------------------------------------------------------------
    // legs
    // ----------------------------------------------------------------
    logic [2:0] auto_w; // auto-on per leg
    // the limit only removes high sides; the disable removes all
    wire [2:0] hs_cmd_w = high_side_phase_input_i & {3{~limit_flag_ff & ~driver_disable_input_i}};
    wire [2:0] ls_cmd_w = (low_side_phase_input_i | {3{brake_hold_w}})
        & {3{~driver_disable_input_i}};
    wire leg_demag_w = demag_en_w & ~driver_disable_input_i;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_leg
            leg_ctrl u_leg (
                .ref_clk_i(ref_clk_i),
                .rst_n_i(rst_n_i),
                .ce_i(ce_i),
                .demag_en_i(leg_demag_w),
                .hs_cmd_i(hs_cmd_w[g]),
                .ls_cmd_i(ls_cmd_w[g]),
                .hs_hold_i(limit_flag_ff),
                .hs_rev_i(high_side_reverse_comparator_i[g]),
                .ls_rev_i(low_side_reverse_comparator_i[g]),
                .hs_gate_o(hs_gate_o[g]),
                .ls_gate_o(ls_gate_o[g]),
                .auto_o(auto_w[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    wire [7:0] status_w = {1'b0, auto_w, ocp_w, demag_en_w, blanking_w, limit_flag_ff};
    wire [7:0] gates_w = {2'h0, ls_gate_o, hs_gate_o};
    // unmapped addresses read as zero
    assign rdata_w = (addr_i == motor_pkg::ADDR_CFG) ? cfg_ff
        : (addr_i == motor_pkg::ADDR_STATUS) ? status_w
        : (addr_i == motor_pkg::ADDR_GATES) ? gates_w : 8'h00;

    // configuration write, read data and pin-level outputs
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cfg_ff <= motor_pkg::CFG_RESET;
            rdata_o <= 8'h00;
            sense_gain_o <= 2'h0;
            ocp_24a_o <= 1'b0;
        end else if (ce_i) begin
            if (wr_i && addr_i == motor_pkg::ADDR_CFG) begin
                cfg_ff <= wdata_i;
            end
            rdata_o <= rd_i ? rdata_w : 8'h00; // valid one cycle only
            sense_gain_o <= gain_w;
            ocp_24a_o <= ocp_w;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_no_shoot;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (hs_gate_o & ls_gate_o) == 3'h0;
    endproperty
    a_no_shoot: assert property (p_no_shoot) else $error("leg shoot-through");

    property p_dead_gap;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && $fell(hs_gate_o[0]) |-> !ls_gate_o[0] ##1 !ls_gate_o[0];
    endproperty
    a_dead_gap: assert property (p_dead_gap) else $error("no dead time");

    property p_hs_held_off;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        limit_flag_ff && $past(limit_flag_ff) && $past(ce_i) |-> hs_gate_o == 3'h0;
    endproperty
    a_hs_held_off: assert property (p_hs_held_off) else $error("high side on in limit");

    property p_trip_sets;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && limit_cmp_i && !blanking_w |=> limit_flag_ff;
    endproperty
    a_trip_sets: assert property (p_trip_sets) else $error("trip missed");

    property p_blank_ignores;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && blanking_w && !limit_flag_ff |=> !limit_flag_ff;
    endproperty
    a_blank_ignores: assert property (p_blank_ignores) else $error("trip in blanking");

    property p_edge_clears;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && limit_flag_ff && hs_rise_w |=> !limit_flag_ff;
    endproperty
    a_edge_clears: assert property (p_edge_clears) else $error("flag kept over edge");

    property p_tick_clears;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && limit_flag_ff && tick_w && hs_any_w |=> !limit_flag_ff ##0 blank_cnt_ff == motor_pkg::BLANK_LOAD;
    endproperty
    a_tick_clears: assert property (p_tick_clears) else $error("no internal restart");

    property p_tick_gap;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        tick_w && ce_i |=> !tick_w [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("restart ticks too close");

    property p_pin_slow;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        pin_config_i |-> !fast_w;
    endproperty
    a_pin_slow: assert property (p_pin_slow) else $error("pin variant not 20 kHz");

    property p_brake;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (ce_i && limit_flag_ff && brake_w && !demag_en_w && !driver_disable_input_i) [*8]
        |-> ls_gate_o == 3'h7;
    endproperty
    a_brake: assert property (p_brake) else $error("brake not applied");

    property p_hiz;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (ce_i && limit_flag_ff && !brake_w && !demag_en_w && low_side_phase_input_i == 3'h0) [*2]
        |-> ls_gate_o == 3'h0;
    endproperty
    a_hiz: assert property (p_hiz) else $error("low side on in high impedance");

    property p_follow_cmd;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && !demag_en_w |=> (hs_gate_o & ~$past(high_side_phase_input_i)) == 3'h0
            && (ls_gate_o & ~$past(ls_cmd_w)) == 3'h0;
    endproperty
    a_follow_cmd: assert property (p_follow_cmd) else $error("gate without command");

    property p_strap_level;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && pin_config_i && strap_taken_ff
        |-> demag_en_w == (strap_ff == motor_pkg::STRAP_OPEN
            || strap_ff == motor_pkg::STRAP_AVDD)
        ##1 ocp_24a_o == (strap_ff == motor_pkg::STRAP_GND_RES
            || strap_ff == motor_pkg::STRAP_AVDD);
    endproperty
    a_strap_level: assert property (p_strap_level) else $error("strap mode wrong");

    c_trip: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        trip_w ##1 limit_flag_ff);
    c_full_duty: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        limit_flag_ff && tick_w && hs_any_w && !hs_rise_w);
    c_auto_on: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        auto_w != 3'h0);
    c_brake: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        brake_hold_w && ls_gate_o == 3'h7);
endmodule

// *** pwm_host_model.sv ***
// ----------------------------------------------------------------
// controller side: phase commands, leg 0 pwm
// ----------------------------------------------------------------
module pwm_host_model #(
    parameter int PERIOD = 200, // pwm period in cycles
    parameter int DUTY = 120 // high cycles per period
) (
    input wire logic clk_i, // reference clock
    input wire logic rst_n_i, // synchronous reset, low
    input wire logic run_i, // high: drive pwm
    input wire logic full_i, // high: 100% duty, no edges
    input wire logic ls_on_i, // high: command leg 0 low side
    output logic [2:0] hs_o, // high-side commands
    output logic [2:0] ls_o // low-side commands
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_ff; // position in pwm period
    // idle keeps the high-side command inputs low to save leakage
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !run_i) begin
            cnt_ff <= 0;
            hs_o <= 3'h0;
        end else begin
            cnt_ff <= (cnt_ff == PERIOD - 1) ? 0 : cnt_ff + 1;
            hs_o <= {2'h0, full_i || (cnt_ff < DUTY)};
        end
    end
    // low side only on request, leg 0: complementary drive for decay tests
    assign ls_o = {2'h0, ls_on_i};
endmodule

// *** motor_bridge_demag_current_limit_tb.sv ***
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
`define WAIT(c) for (wk = 0; wk < 2100 && !(c); wk++) @(posedge ref_clk_i);
module motor_bridge_demag_current_limit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, limit_cmp_i = 1'b0;
    logic run = 1'b0, full = 1'b0, ls_on = 1'b0, wr_i = 1'b0, rd_i = 1'b0, pin_config_i = 1'b1;
    logic [2:0] hs_in, ls_in, hs_rev = 3'h0, ls_rev = 3'h0, hs_gate_o, ls_gate_o;
    logic [1:0] strap = motor_pkg::STRAP_AVDD, gain_strap = 2'h2, sense_gain_o;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o;
    logic ocp_24a_o, overlap = 1'b0, drv_off = 1'b0;
    int err_total = 0, total_checks = 0, cyc = 0, wk;
    pwm_host_model HOST (.clk_i(ref_clk_i), .rst_n_i(rst_n_i), .run_i(run), .full_i(full),
        .ls_on_i(ls_on), .hs_o(hs_in), .ls_o(ls_in));
    motor_bridge_demag_current_limit DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .high_side_phase_input_i(hs_in), .low_side_phase_input_i(ls_in),
        .driver_disable_input_i(drv_off), .high_side_reverse_comparator_i(hs_rev),
        .low_side_reverse_comparator_i(ls_rev), .limit_cmp_i(limit_cmp_i),
        .pin_config_i(pin_config_i), .protect_rectify_strap_i(strap),
        .gain_strap_i(gain_strap), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .hs_gate_o(hs_gate_o), .ls_gate_o(ls_gate_o),
        .sense_gain_o(sense_gain_o), .ocp_24a_o(ocp_24a_o));
    initial forever #12.5 ref_clk_i = ~ref_clk_i;
    // shoot-through watch, sticky so a single glitch cycle is not lost
    always @(negedge ref_clk_i) if (|(hs_gate_o & ls_gate_o)) overlap <= 1'b1;
    // hang guard: the longest wait is one slow internal restart period
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    // read word stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 `CHK(rdata_o, e)
    endtask
    task automatic trip();
        @(posedge ref_clk_i);
        limit_cmp_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        limit_cmp_i <= 1'b0;
        `WAIT(hs_gate_o[0] === 1'b0)
    endtask
    task automatic t_straps_regs();
        repeat (3) @(posedge ref_clk_i);
        `CHK({ocp_24a_o, sense_gain_o}, 3'h6)
        pin_config_i <= 1'b0;
        rd(motor_pkg::ADDR_CFG, motor_pkg::CFG_RESET);
        rd(4'hf, 8'h00);
        wr(motor_pkg::ADDR_STATUS, 8'hff);
        rd(motor_pkg::ADDR_STATUS, 8'h00);
        wr(motor_pkg::ADDR_CFG, 8'h74);
        rd(motor_pkg::ADDR_CFG, 8'h74);
        `CHK({ocp_24a_o, sense_gain_o}, 3'h7)
    endtask
    // full duty: blanking, trip, brake, internal restart at both rates
    task automatic t_limit();
        @(posedge ref_clk_i);
        run <= 1'b1;
        full <= 1'b1;
        `WAIT(hs_gate_o[0] === 1'b1)
        limit_cmp_i <= 1'b1;
        repeat (20) @(posedge ref_clk_i);
        limit_cmp_i <= 1'b0;
        @(posedge ref_clk_i);
        `CHK(hs_gate_o[0], 1'b1)
        repeat (30) @(posedge ref_clk_i);
        trip();
        `CHK(hs_gate_o[0], 1'b0)
        `WAIT(ls_gate_o === 3'h7)
        `CHK(ls_gate_o, 3'h7)
        `WAIT(hs_gate_o[0] === 1'b1)
        `CHK(wk < 2010, 1'b1)
        wr(motor_pkg::ADDR_CFG, 8'h78);
        repeat (50) @(posedge ref_clk_i);
        trip();
        repeat (20) @(posedge ref_clk_i);
        `CHK(ls_gate_o, 3'h0)
        `WAIT(hs_gate_o[0] === 1'b1)
        `CHK(wk < 1010, 1'b1)
        run <= 1'b0;
        full <= 1'b0;
    endtask
    // nothing commanded, diode conduction flagged on legs 1 and 2
    task automatic t_demag(input logic [7:0] cfg, input logic [2:0] exp);
        wr(motor_pkg::ADDR_CFG, cfg);
        repeat (20) @(posedge ref_clk_i);
        ls_rev <= 3'h2;
        hs_rev <= 3'h4;
        repeat (10) @(posedge ref_clk_i);
        `CHK(ls_gate_o[1], 1'b0)
        repeat (30) @(posedge ref_clk_i);
        `CHK({hs_gate_o[2], ls_gate_o[1], hs_gate_o[1]}, exp)
        // a low enable freezes the gates even though the diodes stop
        ce_i <= 1'b0;
        ls_rev <= 3'h0;
        hs_rev <= 3'h0;
        repeat (5) @(posedge ref_clk_i);
        `CHK({hs_gate_o[2], ls_gate_o[1], hs_gate_o[1]}, exp)
        ce_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        `CHK({hs_gate_o, ls_gate_o}, 6'h00)
    endtask
    // complementary low side on leg 0: decay seen, then lost, cuts it
    task automatic t_aar();
        ls_on <= 1'b1;
        `WAIT(ls_gate_o[0] === 1'b1)
        ls_rev <= 3'h1;
        repeat (4) @(posedge ref_clk_i);
        `CHK(ls_gate_o[0], 1'b1)
        ls_rev <= 3'h0;
        repeat (3) @(posedge ref_clk_i);
        `CHK(ls_gate_o[0], 1'b0)
        ls_on <= 1'b0;
    endtask
    // edge-driven pwm: disable blocks all, a trip ends at the next rising edge
    task automatic t_pwm_edge();
        drv_off <= 1'b1;
        run <= 1'b1;
        repeat (20) @(posedge ref_clk_i);
        `CHK({hs_gate_o, ls_gate_o}, 6'h00)
        drv_off <= 1'b0;
        `WAIT(hs_gate_o[0] === 1'b1)
        `CHK(hs_gate_o[0], 1'b1)
        repeat (50) @(posedge ref_clk_i);
        trip();
        `WAIT(hs_gate_o[0] === 1'b1)
        `CHK(wk < 200, 1'b1)
        run <= 1'b0;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        t_straps_regs();
        t_limit();
        t_demag(8'h03, 3'h6);
        t_aar();
        t_demag(8'h00, 3'h0);
        t_pwm_edge();
        `CHK(overlap, 1'b0)
        final_report();
    end
endmodule
